// ==== ivs_regs.svh ====
// Constants for the interrupt vector selector: addresses, vector numbers, levels
`ifndef IVS_REGS_SVH
`define IVS_REGS_SVH

`define IVS_VEC_W 7
`define IVS_NUM_VEC 127
`define IVS_ADDR_W 24
`define IVS_LVL_W 4
`define IVS_ULVL_W 3
`define IVS_CTL2_W 16
`define IVS_ALT_SEL_BIT 15
`define IVS_IVT_BASE 24'h000004
`define IVS_ALTERNATE_VECTOR_TABLE_BASE 24'h000104
`define IVS_ALTERNATE_VECTOR_TABLE_END 24'h0001FE
`define IVS_RESET_ADDR 24'h000000
`define IVS_NO_LVL 4'h0

// Trap vectors and fixed trap levels
`define IVS_VEC_OSC 7'h01
`define IVS_VEC_ADDR 7'h02
`define IVS_VEC_STACK 7'h03
`define IVS_VEC_MATH 7'h04
`define IVS_VEC_DMAERR 7'h05
`define IVS_LVL_OSC 4'hE
`define IVS_LVL_ADDR 4'hD
`define IVS_LVL_STACK 4'hC
`define IVS_LVL_MATH 4'hB
`define IVS_LVL_DMAERR 4'hA

// Peripheral vectors
`define IVS_VEC_EXT0 7'h08
`define IVS_VEC_EXT1 7'h1C
`define IVS_VEC_EXT2 7'h25
`define IVS_VEC_IC1 7'h09
`define IVS_VEC_IC2 7'h0D
`define IVS_VEC_IC7 7'h1E
`define IVS_VEC_IC8 7'h1F
`define IVS_VEC_OC1 7'h0A
`define IVS_VEC_OC2 7'h0E
`define IVS_VEC_OC3 7'h21
`define IVS_VEC_OC4 7'h22
`define IVS_VEC_T1 7'h0B
`define IVS_VEC_T2 7'h0F
`define IVS_VEC_T3 7'h10
`define IVS_VEC_T4 7'h23
`define IVS_VEC_T5 7'h24
`define IVS_VEC_DMA0 7'h0C
`define IVS_VEC_DMA1 7'h16
`define IVS_VEC_DMA2 7'h20
`define IVS_VEC_DMA3 7'h2C
`define IVS_VEC_DMA4 7'h36
`define IVS_VEC_DMA5 7'h45
`define IVS_VEC_DMA6 7'h4C
`define IVS_VEC_DMA7 7'h4D
`define IVS_VEC_U1RX 7'h13
`define IVS_VEC_U1TX 7'h14
`define IVS_VEC_U2RX 7'h26
`define IVS_VEC_U2TX 7'h27
`define IVS_VEC_U1ERR 7'h49
`define IVS_VEC_U2ERR 7'h4A
`define IVS_VEC_SP1ERR 7'h11
`define IVS_VEC_SP1DONE 7'h12
`define IVS_VEC_SP2ERR 7'h28
`define IVS_VEC_SP2DONE 7'h29
`define IVS_VEC_I2C_TGT 7'h18
`define IVS_VEC_I2C_CTL 7'h19
`define IVS_VEC_CAN_RX 7'h2A
`define IVS_VEC_CAN_EVT 7'h2B
`define IVS_VEC_CAN_TX 7'h4E
`define IVS_VEC_ADC 7'h15
`define IVS_VEC_CMP 7'h1A
`define IVS_VEC_CN 7'h1B
`define IVS_VEC_PMP 7'h35
`define IVS_VEC_RTC 7'h46
`define IVS_VEC_CRC 7'h4B

`endif

// ==== ivs_pkg.sv ====
// Types shared by the interrupt vector selector modules
package ivs_pkg;

	typedef logic [126:0] ivs_req_t;
	typedef logic [126:0][3:0] ivs_lvl_arr_t;
	typedef logic [126:0][2:0] ivs_ulvl_t;

	// Request lines grouped by source kind; index order as named
	typedef struct packed {
		logic [4:0] trap;     // 0 osc, 1 addr, 2 stack, 3 math, 4 dma
		logic [2:0] ext;
		logic [3:0] cap;      // capture 1, 2, 7, 8
		logic [3:0] cmp;      // compare 1, 2, 3, 4
		logic [4:0] tmr;
		logic [7:0] dma;
		logic [1:0] uart_rx;
		logic [1:0] uart_tx;
		logic [1:0] uart_err;
		logic [1:0] spi_err;
		logic [1:0] spi_done;
		logic i2c_tgt;
		logic i2c_ctl;
		logic can_rx;
		logic can_evt;
		logic can_tx;
		logic adc;
		logic comparator;
		logic pin_change;
		logic par_port;
		logic rtc;
		logic crc;
	} ivs_src_t;

	typedef struct packed {
		logic alt_sel;
		logic boot_done;
		logic pc_load;
		logic [23:0] pc_value;
		logic req;
		logic [6:0] vec_idx;
		logic [3:0] level;
	} ivs_state_t;

endpackage

// ==== ivs_pick.sv ====
// Picks the highest-level pending vector, lower vector number winning ties
`timescale 1ns/1ps
`default_nettype none
`include "ivs_regs.svh"

module ivs_pick (
	input wire ivs_pkg::ivs_req_t req_in,
	input wire ivs_pkg::ivs_lvl_arr_t lvl_in,
	output logic valid_out,
	output logic [6:0] idx_out,
	output logic [3:0] lvl_out
);

	// ==========================================================
	// Priority scan
	// Scanning downward with >= lets the lower number take a tie
	always_comb begin
		valid_out = 1'b0;
		idx_out = '0;
		lvl_out = `IVS_NO_LVL;
		for (int v = `IVS_NUM_VEC - 1; v >= 0; v--) begin
			if (req_in[v] && (!valid_out || lvl_in[v] >= lvl_out)) begin
				valid_out = 1'b1;
				idx_out = v[6:0];
				lvl_out = lvl_in[v];
			end
		end
	end

endmodule
`default_nettype wire

// ==== ivs_top.sv ====
// Interrupt vector selector: source mapping, table select, vector fetch
`timescale 1ns/1ps
`default_nettype none
`include "ivs_regs.svh"

// Behaviour
// - Select bit set uses alternate table
// - Alternate table follows primary, same slot order
// - Reset bypasses vector mechanism, no table
// - Reset clears state, first fetch at zero
// - Address is base plus twice vector number
// - External requests map to 8, 28, 37
// - Capture and compare channels map as listed
// - DMA completions map to listed vectors
// - Serial port requests map as listed
// - SPI requests map to 17, 18, 40, 41
// - I2C target 24, controller 25
// - CAN requests map to 42, 43, 78
// - Miscellaneous sources map as listed
// - Equal level: lower vector number first
// - Latch pending vector index and level
module ivs_top (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire ivs_pkg::ivs_src_t src_in,
	input wire ivs_pkg::ivs_ulvl_t user_level_in,
	input wire logic [3:0] cpu_ipl_in,
	input wire logic ctl2_wr_in,
	input wire logic [15:0] ctl2_data_in,
	input wire logic vec_ack_in,
	output logic irq_req_out,
	output logic [6:0] pending_vector_index_out,
	output logic [3:0] pending_priority_level_out,
	output logic alt_table_select_out,
	output logic pc_load_out,
	output logic [23:0] pc_value_out
);

	// ==========================================================
	// Source to vector map
	localparam logic [6:0] TRAP_VEC [5] = '{`IVS_VEC_OSC, `IVS_VEC_ADDR,
		`IVS_VEC_STACK, `IVS_VEC_MATH, `IVS_VEC_DMAERR};
	localparam logic [3:0] TRAP_LVL [5] = '{`IVS_LVL_OSC, `IVS_LVL_ADDR,
		`IVS_LVL_STACK, `IVS_LVL_MATH, `IVS_LVL_DMAERR};
	localparam logic [6:0] EXT_VEC [3] = '{`IVS_VEC_EXT0, `IVS_VEC_EXT1,
		`IVS_VEC_EXT2};
	localparam logic [6:0] CAP_VEC [4] = '{`IVS_VEC_IC1, `IVS_VEC_IC2,
		`IVS_VEC_IC7, `IVS_VEC_IC8};
	localparam logic [6:0] CMP_VEC [4] = '{`IVS_VEC_OC1, `IVS_VEC_OC2,
		`IVS_VEC_OC3, `IVS_VEC_OC4};
	localparam logic [6:0] TMR_VEC [5] = '{`IVS_VEC_T1, `IVS_VEC_T2,
		`IVS_VEC_T3, `IVS_VEC_T4, `IVS_VEC_T5};
	localparam logic [6:0] DMA_VEC [8] = '{`IVS_VEC_DMA0, `IVS_VEC_DMA1,
		`IVS_VEC_DMA2, `IVS_VEC_DMA3, `IVS_VEC_DMA4, `IVS_VEC_DMA5,
		`IVS_VEC_DMA6, `IVS_VEC_DMA7};
	localparam logic [6:0] URX_VEC [2] = '{`IVS_VEC_U1RX, `IVS_VEC_U2RX};
	localparam logic [6:0] UTX_VEC [2] = '{`IVS_VEC_U1TX, `IVS_VEC_U2TX};
	localparam logic [6:0] UER_VEC [2] = '{`IVS_VEC_U1ERR, `IVS_VEC_U2ERR};
	localparam logic [6:0] SER_VEC [2] = '{`IVS_VEC_SP1ERR,
		`IVS_VEC_SP2ERR};
	localparam logic [6:0] SDN_VEC [2] = '{`IVS_VEC_SP1DONE,
		`IVS_VEC_SP2DONE};

	ivs_pkg::ivs_req_t req_vec;
	ivs_pkg::ivs_lvl_arr_t lvl_vec;

	// Vectors with no source keep a zero request: reserved slots idle
	always_comb begin
		req_vec = '0;
		for (int i = 0; i < 5; i++) begin
			req_vec[TRAP_VEC[i]] = src_in.trap[i];
			req_vec[TMR_VEC[i]] = src_in.tmr[i];
		end
		for (int i = 0; i < 3; i++) begin
			req_vec[EXT_VEC[i]] = src_in.ext[i];
		end
		for (int i = 0; i < 4; i++) begin
			req_vec[CAP_VEC[i]] = src_in.cap[i];
			req_vec[CMP_VEC[i]] = src_in.cmp[i];
		end
		for (int i = 0; i < 8; i++) begin
			req_vec[DMA_VEC[i]] = src_in.dma[i];
		end
		for (int i = 0; i < 2; i++) begin
			req_vec[URX_VEC[i]] = src_in.uart_rx[i];
			req_vec[UTX_VEC[i]] = src_in.uart_tx[i];
			req_vec[UER_VEC[i]] = src_in.uart_err[i];
			req_vec[SER_VEC[i]] = src_in.spi_err[i];
			req_vec[SDN_VEC[i]] = src_in.spi_done[i];
		end
		req_vec[`IVS_VEC_I2C_TGT] = src_in.i2c_tgt;
		req_vec[`IVS_VEC_I2C_CTL] = src_in.i2c_ctl;
		req_vec[`IVS_VEC_CAN_RX] = src_in.can_rx;
		req_vec[`IVS_VEC_CAN_EVT] = src_in.can_evt;
		req_vec[`IVS_VEC_CAN_TX] = src_in.can_tx;
		req_vec[`IVS_VEC_ADC] = src_in.adc;
		req_vec[`IVS_VEC_CMP] = src_in.comparator;
		req_vec[`IVS_VEC_CN] = src_in.pin_change;
		req_vec[`IVS_VEC_PMP] = src_in.par_port;
		req_vec[`IVS_VEC_RTC] = src_in.rtc;
		req_vec[`IVS_VEC_CRC] = src_in.crc;
	end

	// ==========================================================
	// Levels: traps fixed above every user level
	function automatic logic [3:0] trap_level(input int v);
		trap_level = `IVS_NO_LVL;
		for (int i = 0; i < 5; i++) begin
			if (v == int'(TRAP_VEC[i])) begin
				trap_level = TRAP_LVL[i];
			end
		end
	endfunction

	generate
		for (genvar v = 0; v < `IVS_NUM_VEC; v++) begin : g_lvl
			localparam logic [3:0] TL = trap_level(v);
			assign lvl_vec[v] = (TL != `IVS_NO_LVL) ? TL :
				{1'b0, user_level_in[v]};
		end
	endgenerate

	logic pick_valid;
	logic [6:0] pick_idx;
	logic [3:0] pick_lvl;

	ivs_pick u_pick (
		.req_in(req_vec),
		.lvl_in(lvl_vec),
		.valid_out(pick_valid),
		.idx_out(pick_idx),
		.lvl_out(pick_lvl)
	);

	// ==========================================================
	// Fetch address: same slot offset in either table
	function automatic logic [23:0] vec_addr(input logic alt,
		input logic [6:0] idx);
		logic [23:0] base;
		base = alt ? `IVS_ALTERNATE_VECTOR_TABLE_BASE : `IVS_IVT_BASE;
		vec_addr = base + {{(`IVS_ADDR_W - `IVS_VEC_W - 1){1'b0}}, idx,
			1'b0};
	endfunction

	// ==========================================================
	// State
	ivs_pkg::ivs_state_t st_r;
	ivs_pkg::ivs_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.pc_load = 1'b0;
		if (ctl2_wr_in) begin
			st_nxt.alt_sel = ctl2_data_in[`IVS_ALT_SEL_BIT];
		end
		// Latched whenever a vector is pending; held while nothing is pending
		if (pick_valid) begin
			st_nxt.vec_idx = pick_idx;
			st_nxt.level = pick_lvl;
		end
		st_nxt.req = pick_valid && (pick_lvl > cpu_ipl_in) &&
			st_r.boot_done;
		if (!st_r.boot_done) begin
			// Reset entry never consults either table
			st_nxt.pc_load = 1'b1;
			st_nxt.pc_value = `IVS_RESET_ADDR;
			st_nxt.boot_done = 1'b1;
		end else if (vec_ack_in && st_r.req) begin
			st_nxt.pc_load = 1'b1;
			st_nxt.pc_value = vec_addr(st_r.alt_sel, st_r.vec_idx);
			// Drop the request for a cycle so one ack gives one fetch
			st_nxt.req = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign irq_req_out = st_r.req;
	assign pending_vector_index_out = st_r.vec_idx;
	assign pending_priority_level_out = st_r.level;
	assign alt_table_select_out = st_r.alt_sel;
	assign pc_load_out = st_r.pc_load;
	assign pc_value_out = st_r.pc_value;

	// ==========================================================
	// Checks
	logic tie_bad;
	always_comb begin
		tie_bad = 1'b0;
		for (int v = 0; v < `IVS_NUM_VEC; v++) begin
			if (pick_valid && v < int'(pick_idx) && req_vec[v] &&
				lvl_vec[v] >= pick_lvl) begin
				tie_bad = 1'b1;
			end
		end
	end

	property p_pri_addr;
		@(posedge clk_in) disable iff (rst_in)
		vec_ack_in && irq_req_out && !alt_table_select_out |=>
		pc_load_out && pc_value_out ==
		24'h000004 + {16'h0000, $past(pending_vector_index_out), 1'b0};
	endproperty
	a_pri_addr: assert property (p_pri_addr)
		else $error("primary vector address wrong");

	property p_alt_addr;
		@(posedge clk_in) disable iff (rst_in)
		vec_ack_in && irq_req_out && alt_table_select_out |=>
		pc_load_out && pc_value_out ==
		24'h000104 + {16'h0000, $past(pending_vector_index_out), 1'b0}
		&& pc_value_out <= 24'h0001FE;
	endproperty
	a_alt_addr: assert property (p_alt_addr)
		else $error("alternate vector address wrong");

	property p_boot;
		@(posedge clk_in) $past(rst_in) && !rst_in |=>
		pc_load_out && pc_value_out == 24'h000000 && !irq_req_out;
	endproperty
	a_boot: assert property (p_boot)
		else $error("first fetch after reset not at zero");

	property p_no_irq_reset;
		@(posedge clk_in) rst_in |=> !irq_req_out ##1 !irq_req_out;
	endproperty
	a_no_irq_reset: assert property (p_no_irq_reset)
		else $error("vector request during reset entry");

	property p_sel_reset;
		@(posedge clk_in) rst_in |=> !alt_table_select_out;
	endproperty
	a_sel_reset: assert property (p_sel_reset)
		else $error("table select not cleared by reset");

	property p_sel_write;
		@(posedge clk_in) disable iff (rst_in)
		ctl2_wr_in |=> alt_table_select_out == $past(ctl2_data_in[15]);
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("table select bit not taken from bit 15");

	property p_ext_map;
		@(posedge clk_in) disable iff (rst_in)
		req_vec[8] == src_in.ext[0] && req_vec[28] == src_in.ext[1] &&
		req_vec[37] == src_in.ext[2];
	endproperty
	a_ext_map: assert property (p_ext_map)
		else $error("external request vector map wrong");

	property p_osc_trap;
		@(posedge clk_in) disable iff (rst_in)
		// An accepted ack drops the request for one cycle
		src_in.trap[0] && st_r.boot_done && cpu_ipl_in < 4'hE &&
		!(vec_ack_in && irq_req_out) |=>
		irq_req_out && pending_vector_index_out == 7'h01 &&
		pending_priority_level_out == 4'hE;
	endproperty
	a_osc_trap: assert property (p_osc_trap)
		else $error("oscillator trap not vector 1 at level 14");

	property p_tie;
		@(posedge clk_in) disable iff (rst_in) !tie_bad;
	endproperty
	a_tie: assert property (p_tie)
		else $error("higher vector won a level tie");

	property p_level;
		@(posedge clk_in) disable iff (rst_in)
		irq_req_out |-> pending_priority_level_out > $past(cpu_ipl_in);
	endproperty
	a_level: assert property (p_level)
		else $error("request level not above core level");

	c_alt_fetch: cover property (@(posedge clk_in) disable iff (rst_in)
		alt_table_select_out && vec_ack_in && irq_req_out);
	c_pri_fetch: cover property (@(posedge clk_in) disable iff (rst_in)
		!alt_table_select_out && vec_ack_in && irq_req_out);
	c_trap_pre: cover property (@(posedge clk_in) disable iff (rst_in)
		src_in.trap[1] && src_in.dma[0] ##1 irq_req_out);

endmodule
`default_nettype wire

// ==== ivs_core_model.sv ====
// Core model: takes pending vectors and records each fetch address
`timescale 1ns/1ps
`default_nettype none

module ivs_core_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic en_in,
	input wire logic [3:0] delay_in,
	input wire logic irq_req_in,
	input wire logic [6:0] idx_in,
	input wire logic [3:0] lvl_in,
	input wire logic pc_load_in,
	input wire logic [23:0] pc_value_in,
	output logic ack_out,
	output logic [6:0] taken_idx_out,
	output logic [3:0] taken_lvl_out,
	output logic [23:0] fetch_addr_out,
	output logic [15:0] loads_out
);
	logic [3:0] wait_r;

	initial begin
		ack_out = 1'h0;
		wait_r = 4'h0;
		taken_idx_out = 7'h00;
		taken_lvl_out = 4'h0;
		fetch_addr_out = 24'h000000;
		loads_out = 16'h0000;
	end

	// ==========================================
	// Acknowledge
	// Raised after a falling edge so it stands across the sampling edge;
	// a slow core waits delay_in cycles with the request pending
	always @(negedge clk_in) begin
		if (rst_in || !en_in || !irq_req_in) begin
			ack_out <= 1'h0;
			wait_r <= 4'h0;
		end else if (wait_r >= delay_in) begin
			ack_out <= 1'h1;
		end else begin
			wait_r <= wait_r + 4'h1;
		end
	end

	// ==========================================
	// Fetch capture
	always @(posedge clk_in) begin
		if (ack_out && irq_req_in) begin
			taken_idx_out <= idx_in;
			taken_lvl_out <= lvl_in;
		end
		if (pc_load_in) begin
			fetch_addr_out <= pc_value_in;
			loads_out <= loads_out + 16'h0001;
		end
	end
endmodule

`default_nettype wire

// ==== interrupt_vector_select_bench.sv ====
// Self-checking bench for the interrupt vector selector
`timescale 1ns/1ps
`default_nettype none
`include "ivs_regs.svh"

module interrupt_vector_select_bench;
	logic clk, rst, wr, en, ack, irq, alt, pcl;
	logic [15:0] wdata, nload;
	logic [3:0] ipl, delay, lvl, tlvl;
	logic [6:0] idx, tidx;
	logic [23:0] pcv, faddr;
	ivs_pkg::ivs_src_t src;
	ivs_pkg::ivs_ulvl_t ulvl;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	// Vector expected for each flat bit of the source struct, LSB first
	logic [6:0] vec_of [50] = '{7'h4B, 7'h46, 7'h35, 7'h1B, 7'h1A, 7'h15,
		7'h4E, 7'h2B, 7'h2A, 7'h19, 7'h18, 7'h12, 7'h29, 7'h11, 7'h28,
		7'h49, 7'h4A, 7'h14, 7'h27, 7'h13, 7'h26, 7'h0C, 7'h16, 7'h20,
		7'h2C, 7'h36, 7'h45, 7'h4C, 7'h4D, 7'h0B, 7'h0F, 7'h10, 7'h23,
		7'h24, 7'h0A, 7'h0E, 7'h21, 7'h22, 7'h09, 7'h0D, 7'h1E, 7'h1F,
		7'h08, 7'h1C, 7'h25, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05};

	ivs_top dut (.clk_in(clk), .rst_in(rst), .src_in(src),
		.user_level_in(ulvl), .cpu_ipl_in(ipl), .ctl2_wr_in(wr),
		.ctl2_data_in(wdata), .vec_ack_in(ack), .irq_req_out(irq),
		.pending_vector_index_out(idx), .pending_priority_level_out(lvl),
		.alt_table_select_out(alt), .pc_load_out(pcl), .pc_value_out(pcv));

	ivs_core_model core (.clk_in(clk), .rst_in(rst), .en_in(en),
		.delay_in(delay), .irq_req_in(irq), .idx_in(idx), .lvl_in(lvl),
		.pc_load_in(pcl), .pc_value_in(pcv), .ack_out(ack),
		.taken_idx_out(tidx), .taken_lvl_out(tlvl),
		.fetch_addr_out(faddr), .loads_out(nload));

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	// ==========================================
	// Compare and control tasks
	task automatic stop_test();
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %b", $time, what, got);
		end
	endtask

	task automatic wait_loads(input int n);
		int base;
		base = nload;
		for (int i = 0; i < 40 && nload < base + n; i++) @(negedge clk);
		chk_bit(nload >= base + n, 1'h1, "fetch missing");
	endtask

	// Leaves the core model disabled; callers enable it
	task automatic do_reset(input int n);
		@(negedge clk);
		en = 1'h0;
		rst = 1'h1;
		repeat (n) @(negedge clk);
		chk_bit(pcl, 1'h0, "load in reset");
		rst = 1'h0;
		@(negedge clk);
		chk_bit(pcl, 1'h1, "boot load");
		chk(pcv, `IVS_RESET_ADDR, "boot addr");
		chk_bit(irq, 1'h0, "boot request");
		chk_bit(alt, 1'h0, "select after reset");
	endtask

	task automatic set_alt(input logic [15:0] d);
		@(negedge clk);
		wdata = d;
		wr = 1'h1;
		@(negedge clk);
		wr = 1'h0;
		chk_bit(alt, d[15], "select write");
	endtask

	// ==========================================
	// Scenarios
	task automatic t_map();
		for (int t = 0; t < 2; t++) begin
			set_alt(t ? 16'h8000 : 16'h7FFF);
			for (int p = 0; p < 50; p++) begin
				src = ivs_pkg::ivs_src_t'(50'h1 << p);
				wait_loads(1);
				src = '0;
				chk(24'(tidx), 24'(vec_of[p]), "vector");
				chk(24'(tlvl), 24'(p > 44 ? 59 - p : 1), "level");
				chk(faddr, (t ? `IVS_ALTERNATE_VECTOR_TABLE_BASE : `IVS_IVT_BASE)
					+ {vec_of[p], 1'h0}, "addr");
				repeat (2) @(negedge clk);
				chk(24'(idx), 24'(vec_of[p]), "held index");
			end
		end
	endtask

	task automatic t_prio();
		set_alt(16'h0000);
		delay = 4'h3;
		ulvl[8] = 3'h3;
		ulvl[75] = 3'h3;
		// First external request together with the CRC source
		src = ivs_pkg::ivs_src_t'((50'h1 << 42) | 50'h1);
		wait_loads(1);
		chk(24'(tidx), 24'h8, "tie first");
		src.ext = '0;
		wait_loads(1);
		chk(24'(tidx), 24'h4B, "tie second");
		chk(24'(tlvl), 24'h3, "tie level");
		src = '0;
		repeat (2) @(negedge clk);
		ulvl[75] = 3'h5;
		src = ivs_pkg::ivs_src_t'((50'h1 << 42) | 50'h1);
		wait_loads(1);
		chk(24'(tidx), 24'h4B, "level wins");
		src = '0;
		repeat (2) @(negedge clk);
		ipl = 4'h5;
		src.crc = 1'h1;
		repeat (4) @(negedge clk);
		chk_bit(irq, 1'h0, "core level masks");
		chk(24'(idx), 24'h4B, "masked index");
		chk(24'(lvl), 24'h5, "masked level");
		src = '0;
		ipl = 4'h0;
		delay = 4'h0;
	endtask

	// Trap held through a mid-run reset must not steer the boot fetch
	task automatic t_reset();
		set_alt(16'h8000);
		src.trap[0] = 1'h1;
		do_reset(2);
		en = 1'h1;
		// Converter source alone; the boot load lands first
		src = ivs_pkg::ivs_src_t'(50'h1 << 5);
		wait_loads(2);
		src = '0;
		chk(faddr, `IVS_IVT_BASE + 24'h00002A, "primary after reset");
	endtask

	// ==========================================
	// Main sequence and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end

	initial begin
		rst = 1'h1;
		src = '0;
		ulvl = {127{3'h1}};
		ipl = 4'h0;
		wr = 1'h0;
		wdata = 16'h0000;
		en = 1'h0;
		delay = 4'h0;
		do_reset(8);
		en = 1'h1;
		t_map();
		t_prio();
		t_reset();
		stop_test();
	end
endmodule

`default_nettype wire
